// *** verilog/tcs_top.sv ***
// Purpose: transmit cell configuration registers and the byte path they steer
// Assumes: one 200 MHz clock, synchronous active-high reset, Avalon-MM slave bus
// Notes:   GFC and UTOPIA address pins are synchronised before use
`timescale 1ns/100ps
module tcs_top
    import tcs_pkg::*;
#(
    parameter logic [7:0] P_RST_GFC_CTRL = TCS_RST_GFC_CTRL // control reset value
)
(
    input  wire logic                  i_clk,              // 200 MHz system clock
    input  wire logic                  i_reset,            // synchronous, active high
    // avalon-mm slave
    input  wire logic [TCS_ADDR_W-1:0] i_avs_address,      // byte address
    input  wire logic                  i_avs_read,         // read request
    input  wire logic                  i_avs_write,        // write request
    input  wire logic [7:0]            i_avs_writedata,    // write data
    output logic [7:0]                 o_avs_readdata,     // read data, registered
    output logic                       o_avs_waitrequest,  // stall while request pending
    // transmit byte stream from the framer
    input  wire logic                  i_byte_valid,       // one byte this cycle
    input  wire tcs_byte_s             i_byte,             // tagged byte
    input  wire logic                  i_sts1_mode,        // envelope is STS-1
    output logic                       o_byte_valid,       // registered valid
    output logic [7:0]                 o_byte_data,        // registered byte
    // external pins
    input  wire logic [3:0]            i_gfc_serial_in,    // external GFC bits, async
    input  wire logic [1:0]            i_utp_tx_addr,      // UTOPIA transmit address, async
    input  wire logic                  i_multi_phy,        // multi-PHY mode strap level
    output logic                       o_utp_tx_drive_en,  // transmit UTOPIA outputs active
    // configuration view
    output logic [1:0]                 o_tx_phy_identity   // programmed identity
);

    // register state
    logic [7:0] gfc_ctrl_ff;          // control register
    logic [7:0] nxt_gfc_ctrl;         // next control value
    logic [1:0] phy_id_ff;            // transmit PHY identity
    logic [1:0] nxt_phy_id;           // next identity value

    // bus handshake state
    logic       ack_ff;               // one-cycle acknowledge
    logic [7:0] rdata_ff;             // captured read data
    logic [7:0] nxt_rdata;            // read mux result
    logic       req;                  // a read or write is presented
    logic       take;                 // request completes at this edge
    logic [7:0] req_idx;              // register index of the request
    logic       idx_ok;               // address is word aligned

    // synchronisers
    logic [3:0] gfc_meta_ff;          // first stage, read only by second
    logic [3:0] gfc_sync_ff;          // synchronised GFC bits
    logic [1:0] addr_meta_ff;         // first stage, read only by second
    logic [1:0] addr_sync_ff;         // synchronised UTOPIA address
    logic       multi_meta_ff;        // first stage, read only by second
    logic       multi_sync_ff;        // synchronised mode level

    // byte path
    tcs_cfg_s   cfg;                  // decoded configuration
    logic [7:0] mux_data;             // substituted byte
    logic       valid_ff;             // output valid
    logic [7:0] data_ff;              // output byte
    logic       drive_ff;             // registered UTOPIA drive enable
    logic       nxt_drive;            // next drive enable

    // index decode used by both read and write paths
    function automatic logic hit(input logic [7:0] idx, input logic ok, input logic [7:0] want);
        hit = ok && (idx == want);
    endfunction : hit

    // a request is seen; taken on the edge after the acknowledge rises
    assign req     = i_avs_read || i_avs_write;
    assign take    = req && ack_ff;
    assign req_idx = i_avs_address[TCS_ADDR_W-1:2];
    assign idx_ok  = (i_avs_address[1:0] == 2'h0);

    // waitrequest high on the first cycle of every request, low on the second
    assign o_avs_waitrequest = req && !ack_ff;

    // acknowledge pulse: one cycle, never two in a row so each request is taken once
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            // no request can be half served across a reset
            ack_ff <= 1'b0;
        end
        else
        begin
            // rises one cycle into a request, falls on the take edge
            ack_ff <= req && !ack_ff;
        end
    end

    // control register write path
    always_comb
    begin
        // hold unless a write is taken
        nxt_gfc_ctrl = gfc_ctrl_ff;
        if (take && i_avs_write && hit(req_idx, idx_ok, TCS_IDX_GFC_CTRL))
        begin
            // all eight control bits are writable
            nxt_gfc_ctrl = i_avs_writedata;
        end
    end

    // identity register write path; reserved bits are not stored
    always_comb
    begin
        // hold unless a write is taken
        nxt_phy_id = phy_id_ff;
        if (take && i_avs_write && hit(req_idx, idx_ok, TCS_IDX_PHY_ID))
        begin
            // only the two identity bits are stored
            nxt_phy_id = i_avs_writedata[TCS_PHY_ID_HI:TCS_PHY_ID_LO];
        end
    end

    // control register
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            // default is a parameter so a board can pick its own
            gfc_ctrl_ff <= P_RST_GFC_CTRL;
        end
        else
        begin
            // follow the write path
            gfc_ctrl_ff <= nxt_gfc_ctrl;
        end
    end

    // identity register
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            // identity zero after reset
            phy_id_ff <= TCS_RST_PHY_ID;
        end
        else
        begin
            // follow the write path
            phy_id_ff <= nxt_phy_id;
        end
    end

    // read mux; unmapped or unaligned addresses read as zero
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (hit(req_idx, idx_ok, TCS_IDX_GFC_CTRL))
        begin
            // control register as stored
            nxt_rdata = gfc_ctrl_ff;
        end
        else if (hit(req_idx, idx_ok, TCS_IDX_PHY_ID))
        begin
            // reserved bits read as zero
            nxt_rdata = {6'h00, phy_id_ff};
        end
        else
        begin
            // unmapped: answered normally, data zero
            nxt_rdata = 8'h00;
        end
    end

    // read data captured in the waitrequest cycle so it stands at the take edge
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            // nothing captured yet
            rdata_ff <= 8'h00;
        end
        else if (i_avs_read && !ack_ff)
        begin
            // sampled once per read, in its waitrequest cycle
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_avs_readdata = rdata_ff;

    // two-flop synchroniser for the GFC pins
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            // pins count as zero until the first clean edges
            gfc_meta_ff <= 4'h0;
            gfc_sync_ff <= 4'h0;
        end
        else
        begin
            // first stage may go metastable; only the second reads it
            gfc_meta_ff <= i_gfc_serial_in;
            gfc_sync_ff <= gfc_meta_ff;
        end
    end

    // two-flop synchroniser for the UTOPIA address and mode level
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            // address zero and single-PHY until pins are sampled
            addr_meta_ff  <= 2'h0;
            addr_sync_ff  <= 2'h0;
            multi_meta_ff <= 1'b0;
            multi_sync_ff <= 1'b0;
        end
        else
        begin
            // each bit is synchronised alone; a changing address may skew a cycle
            addr_meta_ff  <= i_utp_tx_addr;
            addr_sync_ff  <= addr_meta_ff;
            multi_meta_ff <= i_multi_phy;
            multi_sync_ff <= multi_meta_ff;
        end
    end

    // field decode into the configuration carrier
    assign cfg.gfc_insert_enable    = gfc_ctrl_ff[TCS_GFC_EN_HI:TCS_GFC_EN_LO];
    assign cfg.fixed_stuff_enable   = gfc_ctrl_ff[TCS_FIX_STUFF_BIT];
    assign cfg.h4_insert_disable    = gfc_ctrl_ff[TCS_H4_DIS_BIT];
    assign cfg.stuff_pattern_select = gfc_ctrl_ff[TCS_PAT_SEL_HI:TCS_PAT_SEL_LO];

    // byte substitution
    tcs_byte_mux u_mux
    (
        .i_byte      (i_byte),
        .i_cfg       (cfg),
        .i_sts1_mode (i_sts1_mode),
        .i_gfc       (gfc_sync_ff),
        .o_data      (mux_data)
    );

    // output byte register; one cycle latency, config changes apply next byte
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            // no byte pending after reset
            valid_ff <= 1'b0;
            data_ff  <= 8'h00;
        end
        else
        begin
            // valid follows the input one cycle late
            valid_ff <= i_byte_valid;
            if (i_byte_valid)
            begin
                data_ff <= mux_data;
            end
        end
    end

    assign o_byte_valid = valid_ff;
    assign o_byte_data  = data_ff;

    // drive enable decision; the identity only matters in multi-PHY mode
    always_comb
    begin
        if (multi_sync_ff)
        begin
            // multi-PHY: answer only to our own address
            nxt_drive = (addr_sync_ff == phy_id_ff);
        end
        else
        begin
            // single-PHY: always selected, identity unused
            nxt_drive = 1'b1;
        end
    end

    // registered drive enable; the synchroniser adds latency the ATM side must allow
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            // outputs quiet while in reset
            drive_ff <= 1'b0;
        end
        else
        begin
            // registered so the enable never glitches on the pins
            drive_ff <= nxt_drive;
        end
    end

    assign o_utp_tx_drive_en = drive_ff;
    assign o_tx_phy_identity = phy_id_ff;

endmodule : tcs_top

// *** verilog/tcs_pkg.sv ***
// Purpose: shared constants and types for the transmit cell / SPE configuration block
// Assumes: 8-bit registers on Avalon-MM, register index times four is the byte address
// Notes:   every offset, field position, reset value and pattern is named once here
package tcs_pkg;

    // register indices; the byte address is four times the index
    localparam logic [7:0] TCS_IDX_GFC_CTRL    = 8'h67;
    localparam logic [7:0] TCS_IDX_PHY_ID      = 8'h68;
    localparam int         TCS_ADDR_W          = 10;

    // control register field positions
    localparam int TCS_GFC_EN_HI      = 7;
    localparam int TCS_GFC_EN_LO      = 4;
    localparam int TCS_FIX_STUFF_BIT  = 3;
    localparam int TCS_H4_DIS_BIT     = 2;
    localparam int TCS_PAT_SEL_HI     = 1;
    localparam int TCS_PAT_SEL_LO     = 0;

    // identity register field positions; bits 7:2 reserved and read as zero
    localparam int TCS_PHY_ID_HI      = 1;
    localparam int TCS_PHY_ID_LO      = 0;

    // reset values
    localparam logic [7:0] TCS_RST_GFC_CTRL = 8'h00;
    localparam logic [1:0] TCS_RST_PHY_ID   = 2'h0;

    // fixed stuff columns of the STS-1 payload envelope
    localparam logic [6:0] TCS_STUFF_COL_A  = 7'h1e; // column 30
    localparam logic [6:0] TCS_STUFF_COL_B  = 7'h3b; // column 59

    // stuff byte patterns by select code
    localparam logic [7:0] TCS_PAT_00       = 8'h00;
    localparam logic [7:0] TCS_PAT_01       = 8'h55;
    localparam logic [7:0] TCS_PAT_10       = 8'haa;
    localparam logic [7:0] TCS_PAT_11       = 8'hff;

    // value sent in place of the calculated path overhead byte
    localparam logic [7:0] TCS_H4_OFF_VAL   = 8'h00;

    // one byte of the outgoing payload stream with its position tags
    typedef struct packed {
        logic [7:0] data;     // payload byte or calculated overhead value
        logic [6:0] col;      // envelope column, 1 based
        logic       is_h4;    // byte sits in the H4 position
        logic       is_hdr1;  // first header byte of a cell, GFC in bits 7:4
    } tcs_byte_s;

    // decoded configuration handed to the byte path
    typedef struct packed {
        logic [3:0] gfc_insert_enable;
        logic       fixed_stuff_enable;
        logic       h4_insert_disable;
        logic [1:0] stuff_pattern_select;
    } tcs_cfg_s;

endpackage : tcs_pkg

// *** verilog/tcs_byte_mux.sv ***
// Purpose: per-byte substitution for the transmit envelope (GFC, stuff, H4)
// Assumes: purely combinational; caller registers the result
// Notes:   stuff columns win over GFC because a stuff column never carries a header
`timescale 1ns/100ps
module tcs_byte_mux
    import tcs_pkg::*;
(
    input  wire tcs_byte_s i_byte,      // incoming tagged byte
    input  wire tcs_cfg_s  i_cfg,       // current configuration
    input  wire logic      i_sts1_mode, // envelope is STS-1
    input  wire logic [3:0] i_gfc,      // synchronised external GFC bits
    output logic [7:0]     o_data       // byte to transmit
);

    // select code to stuff byte
    function automatic logic [7:0] stuff_byte(input logic [1:0] sel);
        unique case (sel)
            2'h0: stuff_byte = TCS_PAT_00;
            2'h1: stuff_byte = TCS_PAT_01;
            2'h2: stuff_byte = TCS_PAT_10;
            2'h3: stuff_byte = TCS_PAT_11;
        endcase
    endfunction : stuff_byte

    logic       is_stuff_col; // byte lies in a fixed stuff column
    logic [3:0] hdr_gfc;      // GFC nibble after per-bit merge

    assign is_stuff_col = (i_byte.col == TCS_STUFF_COL_A) || (i_byte.col == TCS_STUFF_COL_B);

    // each enabled bit takes the external value, others keep the cell's own bit
    assign hdr_gfc = (i_gfc & i_cfg.gfc_insert_enable)
                   | (i_byte.data[7:4] & ~i_cfg.gfc_insert_enable);

    // substitution priority: stuff column, H4 position, cell header, plain payload
    always_comb
    begin
        o_data = i_byte.data;
        if (i_sts1_mode && i_cfg.fixed_stuff_enable && is_stuff_col)
        begin
            o_data = stuff_byte(i_cfg.stuff_pattern_select);
        end
        else if (i_byte.is_h4 && i_cfg.h4_insert_disable)
        begin
            o_data = TCS_H4_OFF_VAL;
        end
        else if (i_byte.is_hdr1)
        begin
            o_data = {hdr_gfc, i_byte.data[3:0]};
        end
        else
        begin
            // no substitution: plain payload passes, including columns 30 and 59 when stuff is off
            o_data = i_byte.data;
        end
    end

endmodule : tcs_byte_mux

// *** tb/tcs_top_monitor.sv ***
// Purpose: concurrent checks on the transmit configuration block ports
// Assumes: a shadow of the control register follows bus writes at the take edge
// Notes:   enabled gfc bits are judged by the bench, async pins make them loose here
`timescale 1ns/100ps
module tcs_top_monitor
    import tcs_pkg::*;
#(
    parameter logic [7:0] P_RST_GFC_CTRL = TCS_RST_GFC_CTRL
)
(
    input wire logic                  i_clk,
    input wire logic                  i_reset,
    input wire logic [TCS_ADDR_W-1:0] i_avs_address,
    input wire logic                  i_avs_write,
    input wire logic [7:0]            i_avs_writedata,
    input wire logic                  o_avs_waitrequest,
    input wire logic                  i_byte_valid,
    input wire tcs_byte_s             i_byte,
    input wire logic                  i_sts1_mode,
    input wire logic                  o_byte_valid,
    input wire logic [7:0]            o_byte_data,
    input wire logic [1:0]            i_utp_tx_addr,
    input wire logic                  i_multi_phy,
    input wire logic                  o_utp_tx_drive_en,
    input wire logic [1:0]            o_tx_phy_identity
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [7:0] cfg_ff;    // shadow of the control register
    logic       stuff_hit; // byte falls in a stuffed column
    logic       h4_hit;    // byte is a suppressed h4
    logic       hdr_hit;   // header byte open to gfc bits
    // shadow moves only at the edge where the bus takes the write
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cfg_ff <= P_RST_GFC_CTRL;
        end
        else if (i_avs_write && !o_avs_waitrequest
                 && i_avs_address == {TCS_IDX_GFC_CTRL, 2'h0})
        begin
            cfg_ff <= i_avs_writedata;
        end
    end
    // priority: stuff, then h4, then gfc
    always_comb
    begin
        stuff_hit = i_sts1_mode && cfg_ff[TCS_FIX_STUFF_BIT]
                    && (i_byte.col == TCS_STUFF_COL_A || i_byte.col == TCS_STUFF_COL_B);
        h4_hit    = !stuff_hit && i_byte.is_h4 && cfg_ff[TCS_H4_DIS_BIT];
        hdr_hit   = !stuff_hit && !h4_hit && i_byte.is_hdr1;
    end
    property p_stuff;
        $past(i_byte_valid && stuff_hit) |-> o_byte_valid && o_byte_data == {4{$past(cfg_ff[1:0])}};
    endproperty
    a_stuff: assert property (p_stuff)
        else $error("stuff column byte wrong");
    property p_h4;
        $past(i_byte_valid && h4_hit) |-> o_byte_valid && o_byte_data == TCS_H4_OFF_VAL;
    endproperty
    a_h4: assert property (p_h4)
        else $error("h4 byte not zero");
    property p_gfc;
        $past(i_byte_valid && hdr_hit) |->
            ((o_byte_data ^ $past(i_byte.data)) & ~{$past(cfg_ff[7:4]), 4'h0}) == 8'h00;
    endproperty
    a_gfc: assert property (p_gfc)
        else $error("disabled gfc bit altered");
    property p_keep;
        $past(i_byte_valid && !stuff_hit && !h4_hit && !hdr_hit)
            |-> o_byte_data == $past(i_byte.data);
    endproperty
    a_keep: assert property (p_keep)
        else $error("payload byte altered");
    property p_match;
        (i_multi_phy && i_utp_tx_addr == o_tx_phy_identity)[*4] |-> o_utp_tx_drive_en;
    endproperty
    a_match: assert property (p_match)
        else $error("matched address not driven");
    property p_miss;
        (i_multi_phy && i_utp_tx_addr != o_tx_phy_identity)[*4] |-> !o_utp_tx_drive_en;
    endproperty
    a_miss: assert property (p_miss)
        else $error("unmatched address driven");
    property p_single;
        (!i_multi_phy)[*4] |-> o_utp_tx_drive_en;
    endproperty
    a_single: assert property (p_single)
        else $error("single mode not driven");
    c_stuff: cover property (i_byte_valid && stuff_hit);
    c_gfc: cover property (i_byte_valid && hdr_hit && cfg_ff[7:4] != 4'h0);
    c_miss: cover property (i_multi_phy && i_utp_tx_addr != o_tx_phy_identity);
endmodule : tcs_top_monitor

bind tcs_top tcs_top_monitor #(.P_RST_GFC_CTRL(P_RST_GFC_CTRL)) i_tcs_top_monitor
(
    .i_clk             (i_clk),
    .i_reset           (i_reset),
    .i_avs_address     (i_avs_address),
    .i_avs_write       (i_avs_write),
    .i_avs_writedata   (i_avs_writedata),
    .o_avs_waitrequest (o_avs_waitrequest),
    .i_byte_valid      (i_byte_valid),
    .i_byte            (i_byte),
    .i_sts1_mode       (i_sts1_mode),
    .o_byte_valid      (o_byte_valid),
    .o_byte_data       (o_byte_data),
    .i_utp_tx_addr     (i_utp_tx_addr),
    .i_multi_phy       (i_multi_phy),
    .o_utp_tx_drive_en (o_utp_tx_drive_en),
    .o_tx_phy_identity (o_tx_phy_identity)
);

// *** tb/tcs_atm_model.sv ***
// Purpose: far side model, the cell source feeding tagged bytes and the tx address
// Assumes: one byte per call, changes made just after a rising edge
// Notes:   once a byte is gone its data turns inverse so stale values never match
`timescale 1ns/100ps
module tcs_atm_model
    import tcs_pkg::*;
(
    input  wire logic  i_clk,   // system clock
    output logic       o_valid, // byte present
    output tcs_byte_s  o_byte,  // tagged byte
    output logic [1:0] o_addr   // utopia transmit address
);
    initial
    begin
        o_valid = 1'b0;
        o_byte  = '0;
        o_addr  = 2'h0;
    end
    // one byte, valid for exactly one edge
    task automatic send(input logic [7:0] d, input logic [6:0] c, input logic h4, input logic hd);
    begin
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_byte  <= '{data: d, col: c, is_h4: h4, is_hdr1: hd};
        @(posedge i_clk);
        o_valid     <= 1'b0;
        o_byte.data <= ~d;
    end
    endtask : send
    // select a phy on the address bus
    task automatic put_addr(input logic [1:0] a);
    begin
        @(posedge i_clk);
        o_addr <= a;
    end
    endtask : put_addr
endmodule : tcs_atm_model

// *** tb/tb.sv ***
// Purpose: register and byte path test of the transmit configuration block
// Assumes: avalon slave may insert waits, output byte one edge after input
// Notes:   gfc pins stay at one value so the synchroniser has settled
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    begin \
        n_compared++; \
        if ((got) !== (ex)) \
        begin \
            err_count++; \
            $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
        end \
    end
module tb;
    import tcs_pkg::*;
    localparam logic [7:0] P_RST_GFC_CTRL_TB = TCS_RST_GFC_CTRL; // control reset as built
    logic            i_clk, i_reset, i_avs_read, i_avs_write, i_byte_valid;
    logic            i_sts1_mode, i_multi_phy, o_avs_waitrequest, o_byte_valid;
    logic            o_utp_tx_drive_en;
    logic [9:0]      i_avs_address;
    logic [7:0]      i_avs_writedata, o_avs_readdata, o_byte_data, rd;
    logic [3:0]      i_gfc_serial_in;
    logic [1:0]      i_utp_tx_addr, o_tx_phy_identity;
    tcs_byte_s       i_byte;
    int              err_count, n_compared;
    logic [7:0]      pat [4] = '{8'h00, 8'h55, 8'haa, 8'hff};
    logic [7:0]      g_ctl [4] = '{8'h50, 8'ha0, 8'hf0, 8'h00};
    logic [7:0]      g_exp [4] = '{8'he3, 8'h73, 8'h63, 8'hf3};
    tcs_top i_tcs_top (.i_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_byte_valid, .i_byte,
        .i_sts1_mode, .o_byte_valid, .o_byte_data, .i_gfc_serial_in, .i_utp_tx_addr,
        .i_multi_phy, .o_utp_tx_drive_en, .o_tx_phy_identity);
    tcs_atm_model i_tcs_atm_model (.i_clk, .o_valid(i_byte_valid), .o_byte(i_byte),
        .o_addr(i_utp_tx_addr));
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // one bus cycle; held until waitrequest is seen low, read data taken there
    task automatic av(input logic w, input logic [9:0] a, input logic [7:0] d);
    begin
        @(posedge i_clk);
        i_avs_write     <= w;
        i_avs_read      <= !w;
        i_avs_address   <= a;
        i_avs_writedata <= d;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read  <= 1'b0;
    end
    endtask : av
    // send one byte and wait until its result stands
    task automatic bt(input logic [7:0] d, input logic [6:0] c, input logic h4, input logic hd);
    begin
        i_tcs_atm_model.send(d, c, h4, hd);
        @(posedge i_clk);
    end
    endtask : bt
    task automatic close_out;
    begin
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask : close_out
    // hang guard, the sequence needs well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge i_clk);
        err_count++;
        close_out();
    end
    initial
    begin
        {i_reset, i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = '0;
        i_reset         = 1'b1;
        i_sts1_mode     = 1'b1;
        i_multi_phy     = 1'b0;
        i_gfc_serial_in = 4'h6;
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        av(0, 10'h19c, 8'h00);
        `CHK("ctrl reset", P_RST_GFC_CTRL_TB, rd)
        av(0, 10'h1a0, 8'h00);
        `CHK("id reset", 8'h00, rd)
        av(1, 10'h1a4, 8'h5a);
        av(0, 10'h1a4, 8'h00);
        `CHK("unmapped", 8'h00, rd)
        av(1, 10'h1a0, 8'hff);
        av(0, 10'h1a0, 8'h00);
        `CHK("id readback", 8'h03, rd)
        `CHK("id pins", 2'h3, o_tx_phy_identity)
        for (int k = 0; k < 4; k++)
        begin
            av(1, 10'h19c, 8'h08 | 8'(k));
            av(0, 10'h19c, 8'h00);
            `CHK("ctrl readback", 8'h08 | 8'(k), rd)
            bt(8'h12, 7'd30, 1'b0, 1'b0);
            `CHK("stuff col a", pat[k], o_byte_data)
            bt(8'h12, 7'd59, 1'b1, 1'b1);
            `CHK("stuff col b", pat[k], o_byte_data)
        end
        bt(8'h12, 7'd31, 1'b0, 1'b0);
        `CHK("next col", 8'h12, o_byte_data)
        i_sts1_mode <= 1'b0;
        bt(8'h34, 7'd30, 1'b0, 1'b0);
        `CHK("not sts1", 8'h34, o_byte_data)
        i_sts1_mode <= 1'b1;
        av(1, 10'h19c, 8'h04);
        bt(8'h3c, 7'd5, 1'b1, 1'b0);
        `CHK("h4 off", 8'h00, o_byte_data)
        av(1, 10'h19c, 8'h00);
        bt(8'h56, 7'd30, 1'b0, 1'b0);
        `CHK("no stuff a", 8'h56, o_byte_data)
        bt(8'h3c, 7'd59, 1'b1, 1'b0);
        `CHK("h4 on", 8'h3c, o_byte_data)
        for (int k = 0; k < 4; k++)
        begin
            av(1, 10'h19c, g_ctl[k]);
            bt(8'hf3, 7'd10, 1'b0, 1'b1);
            `CHK("gfc header", g_exp[k], o_byte_data)
        end
        repeat (4) @(posedge i_clk);
        `CHK("single drive", 1'b1, o_utp_tx_drive_en)
        i_multi_phy <= 1'b1;
        i_tcs_atm_model.put_addr(2'h3);
        repeat (4) @(posedge i_clk);
        `CHK("match drive", 1'b1, o_utp_tx_drive_en)
        i_tcs_atm_model.put_addr(2'h2);
        repeat (4) @(posedge i_clk);
        `CHK("miss drive", 1'b0, o_utp_tx_drive_en)
        i_multi_phy <= 1'b0;
        repeat (4) @(posedge i_clk);
        `CHK("single miss", 1'b1, o_utp_tx_drive_en)
        // mid-run reset must bring both registers back to their defaults
        av(1, 10'h19c, 8'h0f);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        `CHK("drive in reset", 1'b0, o_utp_tx_drive_en)
        i_reset <= 1'b0;
        av(0, 10'h19c, 8'h00);
        `CHK("ctrl re-reset", P_RST_GFC_CTRL_TB, rd)
        av(0, 10'h1a0, 8'h00);
        `CHK("id re-reset", 8'h00, rd)
        close_out();
    end
endmodule : tb
